/* rtl/asc_defs.vh */
// Purpose: constants for the asynchronous static memory host controller
// Assumes: 100 MHz mclk_i, one access at a time
// Notes: times in ns/us as printed, cycle counts derived
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH
`define ASC_CLK_PERIOD_NS 10
`define ASC_ADDR_W 19
`define ASC_DATA_W 8
`define ASC_T_POWER_US 100
`define ASC_T_RC_NS 12
`define ASC_T_AA_NS 12
`define ASC_T_PWE_NS 8
`define ASC_T_SD_NS 6
`define ASC_T_R_NS 12
`define ASC_T_HZWE_NS 6
// least times round up to whole cycles
`define ASC_CYC_UP(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_POWER_CYC ((`ASC_T_POWER_US * 1000) / `ASC_CLK_PERIOD_NS)
`define ASC_RD_CYC `ASC_CYC_UP(`ASC_T_AA_NS)
`define ASC_WR_CYC `ASC_CYC_UP(`ASC_T_PWE_NS)
`define ASC_REC_CYC `ASC_CYC_UP(`ASC_T_R_NS)
`define ASC_TURN_CYC `ASC_CYC_UP(`ASC_T_HZWE_NS)
`define ASC_CNT_W 14
`endif

/* rtl/asc_timer.v */
// Purpose: down counter giving wait intervals in clock cycles
// Assumes: load has priority over counting
// Notes: done is high while count is zero
`timescale 1ns/1ps
`include "asc_defs.vh"
module asc_timer (
    input wire mclk_i,
    input wire rst_i,
    input wire load_i,
    input wire [`ASC_CNT_W-1:0] value_i,
    output wire done_o
);
    reg [`ASC_CNT_W-1:0] cnt_reg;
    // count to zero and rest there
    always @(posedge mclk_i) begin
        if (rst_i)
            cnt_reg <= {`ASC_CNT_W{1'b0}};
        else if (load_i)
            cnt_reg <= value_i;
        else if (cnt_reg != {`ASC_CNT_W{1'b0}})
            cnt_reg <= cnt_reg - 1'b1;
    end
    // done must not look at load: the controller loads on done, a loop otherwise
    assign done_o = (cnt_reg == {`ASC_CNT_W{1'b0}});
endmodule // asc_timer

/* rtl/asc_pin_io.v */
// Purpose: registered data pin drive and read capture
// Assumes: oe high while host drives the bus
// Notes: read data captured only on capture strobe
`timescale 1ns/1ps
`include "asc_defs.vh"
module asc_pin_io (
    input wire mclk_i,
    input wire rst_i,
    input wire drive_i,
    input wire [`ASC_DATA_W-1:0] wdata_i,
    input wire capture_i,
    input wire [`ASC_DATA_W-1:0] dq_i,
    output reg [`ASC_DATA_W-1:0] dq_o,
    output reg dq_oe_o,
    output reg [`ASC_DATA_W-1:0] rdata_o
);
    // output and capture flops
    always @(posedge mclk_i) begin
        if (rst_i) begin
            dq_o <= 8'h00;
            dq_oe_o <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            dq_oe_o <= drive_i;
            if (drive_i)
                dq_o <= wdata_i;
            if (capture_i)
                rdata_o <= dq_i;
        end
    end
endmodule // asc_pin_io

/* rtl/asc_ctrl.v */
// Purpose: host controller driving a 512K x 8 asynchronous static memory
// Assumes: one request at a time, req_i taken while ready_o is high
// Notes: all pin outputs come from flops, so pins never glitch
`timescale 1ns/1ps
`include "asc_defs.vh"
module asc_ctrl #(
    parameter POWER_CYC = `ASC_POWER_CYC
) (
    input wire mclk_i,
    input wire rst_i,
    input wire req_i,
    input wire we_i,
    input wire [`ASC_ADDR_W-1:0] addr_i,
    input wire [`ASC_DATA_W-1:0] wdata_i,
    input wire retain_req_i,
    input wire retain_exit_i,
    output wire ready_o,
    output reg done_o,
    output wire [`ASC_DATA_W-1:0] rdata_o,
    output reg retain_ok_o,
    output reg [`ASC_ADDR_W-1:0] mem_addr_o,
    output reg mem_cs_n_o,
    output reg mem_oe_n_o,
    output reg mem_we_n_o,
    input wire [`ASC_DATA_W-1:0] mem_dq_i,
    output wire [`ASC_DATA_W-1:0] mem_dq_o,
    output wire mem_dq_oe_o
);
    localparam [6:0] S_POWER = 7'h01;
    localparam [6:0] S_IDLE = 7'h02;
    localparam [6:0] S_READ = 7'h04;
    localparam [6:0] S_WSET = 7'h08;
    localparam [6:0] S_WPULSE = 7'h10;
    localparam [6:0] S_WEND = 7'h20;
    localparam [6:0] S_RETAIN = 7'h40;

    reg [6:0] state_reg, state_next;
    reg [`ASC_DATA_W-1:0] wdata_reg;
    reg tmr_load;
    reg [`ASC_CNT_W-1:0] tmr_value;
    reg drive;
    reg capture;
    wire tmr_done;
    reg pwr_loaded_reg;
    reg [`ASC_CNT_W+3:0] pwr_cnt_reg;
    wire pwr_busy = (pwr_cnt_reg != {(`ASC_CNT_W+4){1'b0}});

    // cycle count to timer width
    function [`ASC_CNT_W-1:0] cyc;
        input integer n;
        begin
            cyc = n[`ASC_CNT_W-1:0];
        end
    endfunction

    asc_timer u_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .load_i(tmr_load),
        .value_i(tmr_value),
        .done_o(tmr_done)
    );

    asc_pin_io u_pin (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .drive_i(drive),
        .wdata_i(wdata_reg),
        .capture_i(capture),
        .dq_i(mem_dq_i),
        .dq_o(mem_dq_o),
        .dq_oe_o(mem_dq_oe_o),
        .rdata_o(rdata_o)
    );

    assign ready_o = (state_reg == S_IDLE) && tmr_done && !retain_req_i;

    // next state and timer loads
    always @* begin
        state_next = state_reg;
        tmr_load = 1'b0;
        tmr_value = {`ASC_CNT_W{1'b0}};
        drive = 1'b0;
        capture = 1'b0;
        case (state_reg)
            S_POWER: begin
                // the short access timer is idle here, only the long count counts
                if (pwr_loaded_reg && !pwr_busy)
                    state_next = S_IDLE;
            end
            S_IDLE: begin
                if (tmr_done && retain_req_i) begin
                    state_next = S_RETAIN; // cs already high
                end else if (ready_o && req_i && we_i) begin
                    state_next = S_WSET; // address before strobe
                end else if (ready_o && req_i) begin
                    state_next = S_READ;
                    tmr_load = 1'b1;
                    tmr_value = cyc(`ASC_RD_CYC);
                end
            end
            S_READ: begin
                if (tmr_done) begin
                    capture = 1'b1; // sampled after access time
                    state_next = S_IDLE;
                    tmr_load = 1'b1;
                    tmr_value = cyc(`ASC_TURN_CYC); // bus release before next drive
                end
            end
            S_WSET: begin
                drive = 1'b1;
                state_next = S_WPULSE;
                tmr_load = 1'b1;
                tmr_value = cyc(`ASC_WR_CYC);
            end
            S_WPULSE: begin
                drive = 1'b1;
                if (tmr_done)
                    state_next = S_WEND;
            end
            S_WEND: begin
                drive = 1'b1; // data held past strobe rise
                state_next = S_IDLE;
            end
            S_RETAIN: begin
                if (retain_exit_i) begin
                    state_next = S_IDLE;
                    tmr_load = 1'b1;
                    tmr_value = cyc(`ASC_REC_CYC);
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // state and power-up wait
    always @(posedge mclk_i) begin
        if (rst_i)
            state_reg <= S_POWER;
        else
            state_reg <= state_next;
    end

    // power-up count loaded once at release; a long wait uses the parameter
    always @(posedge mclk_i) begin
        if (rst_i) begin
            pwr_loaded_reg <= 1'b0;
            pwr_cnt_reg <= {(`ASC_CNT_W+4){1'b0}};
        end else if (!pwr_loaded_reg) begin
            pwr_loaded_reg <= 1'b1;
            pwr_cnt_reg <= POWER_CYC[`ASC_CNT_W+3:0];
        end else if (pwr_busy) begin
            pwr_cnt_reg <= pwr_cnt_reg - 1'b1;
        end
    end

    // pins: strobes and address from flops, no glitches
    always @(posedge mclk_i) begin
        if (rst_i) begin
            mem_addr_o <= {`ASC_ADDR_W{1'b0}};
            mem_cs_n_o <= 1'b1; // deselected means standby
            mem_oe_n_o <= 1'b1;
            mem_we_n_o <= 1'b1;
            wdata_reg <= 8'h00;
            done_o <= 1'b0;
            retain_ok_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            retain_ok_o <= (state_next == S_RETAIN);
            if (ready_o && req_i) begin
                mem_addr_o <= addr_i;
                wdata_reg <= wdata_i;
            end
            case (state_next)
                S_READ: begin
                    mem_cs_n_o <= 1'b0;
                    mem_oe_n_o <= 1'b0;
                    mem_we_n_o <= 1'b1;
                end
                S_WSET: begin
                    mem_cs_n_o <= 1'b1;
                    mem_oe_n_o <= 1'b1; // memory bus floats
                    mem_we_n_o <= 1'b1;
                end
                S_WPULSE: begin
                    mem_cs_n_o <= 1'b0;
                    mem_oe_n_o <= 1'b1;
                    mem_we_n_o <= 1'b0;
                end
                default: begin
                    mem_cs_n_o <= 1'b1; // address kept through this edge
                    mem_oe_n_o <= 1'b1;
                    mem_we_n_o <= 1'b1;
                end
            endcase
            if ((state_reg == S_READ && tmr_done) || state_reg == S_WEND)
                done_o <= 1'b1;
        end
    end

endmodule // asc_ctrl

/* testbench/asc_ctrl_chk.sv */
// Purpose: pin protocol checks for asc_ctrl
// Assumes: all pins come from flops on mclk_i
// Notes: power wait is counted here, not taken from the design
`timescale 1ns/1ps
module asc_chk #(parameter POWER_CYC = 20) (
    input wire mclk_i,
    input wire rst_i,
    input wire done_o,
    input wire retain_ok_o,
    input wire [7:0] rdata_o,
    input wire [18:0] mem_addr_o,
    input wire mem_cs_n_o,
    input wire mem_oe_n_o,
    input wire mem_we_n_o,
    input wire [7:0] mem_dq_i,
    input wire [7:0] mem_dq_o,
    input wire mem_dq_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    reg [15:0] pw_reg;
    // cycles since reset release, saturating so it cannot wrap
    always @(posedge mclk_i) begin
        if (rst_i)
            pw_reg <= 16'h0000;
        else if (pw_reg < POWER_CYC)
            pw_reg <= pw_reg + 16'h0001;
    end
    a_power_wait: assert property (pw_reg < POWER_CYC |-> mem_cs_n_o)
        else $error("access before power wait");
    a_read_strobes: assert property (!mem_oe_n_o |-> !mem_cs_n_o && mem_we_n_o && !mem_dq_oe_o)
        else $error("bad read strobes");
    a_read_len: assert property ($fell(mem_oe_n_o) |-> !mem_oe_n_o [*3] ##1 done_o)
        else $error("read too short or late");
    a_read_capture: assert property (done_o && $past(!mem_oe_n_o) |-> rdata_o == $past(mem_dq_i))
        else $error("read data not captured");
    a_write_drive: assert property (!mem_we_n_o |-> mem_dq_oe_o && !mem_cs_n_o && mem_oe_n_o)
        else $error("write without data drive");
    a_write_setup: assert property ($fell(mem_we_n_o) |-> mem_dq_oe_o && $stable(mem_addr_o))
        else $error("write setup broken");
    a_write_hold: assert property (!mem_we_n_o ##1 !mem_we_n_o |-> $stable({mem_addr_o, mem_dq_o}))
        else $error("write pins moved");
    a_write_end: assert property ($rose(mem_we_n_o) |-> mem_dq_oe_o && $stable(mem_dq_o))
        else $error("data dropped before write end");
    a_retain_desel: assert property (retain_ok_o |-> mem_cs_n_o)
        else $error("selected in retention");
    a_retain_recov: assert property ($fell(retain_ok_o) |-> mem_cs_n_o [*2])
        else $error("access too soon after retention");
    c_read: cover property ($fell(mem_oe_n_o) ##3 done_o);
    c_write: cover property ($rose(mem_we_n_o));
    c_retain: cover property ($fell(retain_ok_o));
endmodule // asc_chk
bind asc_ctrl asc_chk #(.POWER_CYC(POWER_CYC)) i_asc_chk (.mclk_i, .rst_i, .done_o,
    .retain_ok_o, .rdata_o, .mem_addr_o, .mem_cs_n_o, .mem_oe_n_o, .mem_we_n_o,
    .mem_dq_i, .mem_dq_o, .mem_dq_oe_o);

/* testbench/asc_mem_model.sv */
// Purpose: behavioural 512K x 8 asynchronous static memory
// Assumes: host strobes are active low
// Notes: undriven bus toggles every ns so a late sample reads garbage
`timescale 1ns/1ps
module asc_mem_model (
    input wire [18:0] addr_i,
    input wire cs_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire [7:0] host_dq_i,
    input wire host_oe_i,
    output wire [7:0] dq_o
);
    logic [7:0] mem [0:524287];
    logic [7:0] out_q = 8'h00;
    logic wr_pend = 1'b0;
    realtime t_a = 0.0, t_c = 0.0, t_o = 0.0, t_v;
    // edge times; select needs no power-up delay
    always @(addr_i) t_a = $realtime;
    always @(negedge cs_n_i) t_c = $realtime;
    always @(negedge oe_n_i) t_o = $realtime;
    // read path polled each ns, slowest of the three access paths wins
    always #1 begin
        t_v = ((t_a > t_c) ? t_a : t_c) + 12.0;
        if (t_o + 6.0 > t_v) t_v = t_o + 6.0;
        if (!cs_n_i && !oe_n_i && we_n_i && $realtime >= t_v)
            out_q = mem[addr_i];
        else if ($realtime >= t_a + 3.0)
            out_q = ~out_q;
    end
    assign dq_o = host_oe_i ? host_dq_i : out_q;
    // write armed by overlap, stored at whichever strobe rises first
    always @* if (!cs_n_i && !we_n_i) wr_pend = 1'b1;
    always @(posedge cs_n_i or posedge we_n_i) begin
        if (wr_pend) begin
            mem[addr_i] = host_dq_i;
            wr_pend = 1'b0;
        end
    end
endmodule // asc_mem_model

/* testbench/tb_top.sv */
// Purpose: self-checking bench for asc_ctrl with memory model
// Assumes: inputs change on the falling edge
// Notes: power wait shortened through POWER_CYC
`timescale 1ns/1ps
module tb_top;
    localparam PW = 20;
    logic mclk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, we_i = 1'b0;
    logic retain_req_i = 1'b0, retain_exit_i = 1'b0;
    logic [18:0] addr_i = 19'h00000, a;
    logic [7:0] wdata_i = 8'h00;
    wire ready_o, done_o, retain_ok_o, mem_cs_n_o, mem_oe_n_o, mem_we_n_o, mem_dq_oe_o;
    wire [7:0] rdata_o, mem_dq_i, mem_dq_o;
    wire [18:0] mem_addr_o;
    int fails = 0, n_checks = 0, seed = 37854, k;
    logic [7:0] sb [logic [18:0]];
    asc_ctrl #(.POWER_CYC(PW)) i_asc_ctrl (.mclk_i, .rst_i, .req_i, .we_i, .addr_i,
        .wdata_i, .retain_req_i, .retain_exit_i, .ready_o, .done_o, .rdata_o,
        .retain_ok_o, .mem_addr_o, .mem_cs_n_o, .mem_oe_n_o, .mem_we_n_o, .mem_dq_i,
        .mem_dq_o, .mem_dq_oe_o);
    asc_mem_model i_asc_mem_model (.addr_i(mem_addr_o), .cs_n_i(mem_cs_n_o),
        .oe_n_i(mem_oe_n_o), .we_n_i(mem_we_n_o), .host_dq_i(mem_dq_o),
        .host_oe_i(mem_dq_oe_o), .dq_o(mem_dq_i));
    always #5 mclk_i = ~mclk_i;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // one access; bounded waits so a stuck handshake fails instead of hanging
    task automatic access(input logic w, input logic [18:0] ad, input logic [7:0] d);
        @(negedge mclk_i);
        req_i = 1'b1;
        we_i = w;
        addr_i = ad;
        wdata_i = d;
        for (k = 0; k < 50 && ready_o !== 1'b1; k++) @(negedge mclk_i);
        check("ready", ready_o, 8'h01);
        @(negedge mclk_i);
        req_i = 1'b0;
        for (k = 0; k < 20 && done_o !== 1'b1; k++) @(negedge mclk_i);
        check("done", done_o, 8'h01);
        if (w) sb[ad] = d;
        else check("rdata", rdata_o, sb[ad]);
        @(negedge mclk_i);
        check("done pulse", done_o, 8'h00);
    endtask
    task print_verdict;
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog far beyond the expected few microseconds
    initial begin
        #100us;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (20) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        check("ready early", ready_o, 8'h00);
        repeat (PW) @(negedge mclk_i);
        check("cs idle", mem_cs_n_o, 8'h01);
        // address extremes, back to back
        access(1'b1, 19'h00000, 8'hff);
        access(1'b1, 19'h7ffff, 8'h00);
        access(1'b0, 19'h7ffff, 8'h00);
        access(1'b0, 19'h00000, 8'h00);
        for (int i = 0; i < 60; i++) begin
            a = 19'($random(seed)) & 19'h7000f;
            if (!sb.exists(a) || $random(seed) % 2)
                access(1'b1, a, 8'($random(seed)));
            else
                access(1'b0, a, 8'h00);
        end
        // park, recover, then every stored byte must read back
        @(negedge mclk_i);
        retain_req_i = 1'b1;
        for (k = 0; k < 20 && retain_ok_o !== 1'b1; k++) @(negedge mclk_i);
        check("retain ok", retain_ok_o, 8'h01);
        check("retain cs", mem_cs_n_o, 8'h01);
        repeat (5) @(negedge mclk_i);
        retain_req_i = 1'b0;
        retain_exit_i = 1'b1;
        @(negedge mclk_i);
        retain_exit_i = 1'b0;
        for (k = 0; k < 20 && retain_ok_o !== 1'b0; k++) @(negedge mclk_i);
        check("retain exit", retain_ok_o, 8'h00);
        foreach (sb[x]) access(1'b0, x, 8'h00);
        print_verdict();
    end
endmodule // tb_top
